/* core/multichannel_dma_control.sv */
// Four-channel DMA engine: registers, arbitration and transfer sequencing
`timescale 1ns/1ps
// Behaviour
// - Engine enable off aborts all channels
// - Priority select: one round-robin, zero fixed
// - Null write adds dummy write to source
// - Reload restores pointers and count at start
// - Repeated modes always restore count
// - Software request starts; cleared on completion
// - Software request follows transfer mode
// - Source addressing: indirect, dec, inc, hold
// - Destination addressing uses same codes
// - Transfer mode field selects four modes
// - Size one byte, zero word default
// - Disabled channel ignores all requests
// - Each channel powered down independently
// - Unimplemented engine control bits read zero
// - Original pointers and count stored for reload
// - Engine and per-channel register set present
// - Out-of-limit access terminates, raises flag
// - Byte transfers use address LSB lane
// - One-shot single, continuous until count exhausted
// - Fixed lowest wins; round robin skips the last grant unless it alone is pending
module multichannel_dma_control #(
    parameter int NUM_CH = dma_pkg::NUM_CH
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic [dma_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [15:0]                reg_wdata,
    input  wire logic                       reg_write,
    input  wire logic                       reg_read,
    output logic      [15:0]                reg_rdata,
    input  wire logic [NUM_CH-1:0]          trigger,
    input  wire logic [NUM_CH-1:0]          indirect_offset_valid,
    input  wire logic [15:0]                indirect_offset,
    output dma_pkg::mem_req_s               mem_req,
    input  wire logic                       mem_ready,
    input  wire logic [15:0]                mem_rdata,
    output logic      [NUM_CH-1:0]          channel_event
);
    typedef enum {S_IDLE, S_READ, S_WRITE, S_DUMMY} state_e;

    logic                    engine_enable;
    logic                    priority_scheme_select;
    logic [15:0]             upper_address_limit;
    logic [15:0]             lower_address_limit;
    logic [15:0]             transfer_data_buffer;
    logic [NUM_CH-1:0]       module_power_down;
    dma_pkg::channel_control_s ctl [NUM_CH];
    logic [15:0]             source_pointer [NUM_CH];
    logic [15:0]             destination_pointer [NUM_CH];
    logic [15:0]             transaction_counter [NUM_CH];
    logic [15:0]             original_count [NUM_CH];
    logic [15:0]             src_start [NUM_CH];
    logic [15:0]             dst_start [NUM_CH];
    logic [3:0]              flags [NUM_CH];
    logic [NUM_CH-1:0]       pending;
    logic [NUM_CH-1:0]       restart;
    logic [NUM_CH-1:0]       last_grant;
    logic [1:0]              cur;
    state_e                  state;
    logic [15:0]             read_data;

    function automatic logic [15:0] step(input logic [15:0] p, input dma_pkg::addr_mode_e m, input logic b);
        logic [15:0] d;
        d = b ? 16'h0001 : 16'h0002;
        case (m)
            dma_pkg::ADDR_INC: step = p + d;
            dma_pkg::ADDR_DEC: step = p - d;
            default:           step = p;
        endcase
    endfunction

    function automatic logic in_limits(input logic [15:0] a);
        in_limits = (a < 16'h1000) || ((a >= lower_address_limit) && (a <= upper_address_limit));
    endfunction

    // Register decode
    wire        is_ch    = reg_addr >= dma_pkg::OFF_CH_BASE;
    wire [5:0]  ch_rel   = reg_addr - dma_pkg::OFF_CH_BASE;
    wire [1:0]  sel_ch   = ch_rel[4:3];
    wire [2:0]  sel_sub  = ch_rel[2:0];
    wire        ch_hit   = is_ch && (ch_rel[5] == 1'b0) && (32'(sel_ch) < NUM_CH);
    wire [NUM_CH-1:0] live;

    genvar g;
    for (g = 0; g < NUM_CH; g++) begin : g_live
        assign live[g] = engine_enable && ctl[g].channel_enable && !module_power_down[g];
    end

    // Arbitration: fixed lowest first, or lowest pending other than the last grant
    logic [1:0] winner;
    logic       any_win;
    always_comb begin
        logic [1:0] idx;
        winner  = 2'd0;
        any_win = 1'b0;
        idx     = 2'd0;
        for (int k = NUM_CH - 1; k >= 0; k--) begin
            if (pending[k] && live[k] && !(priority_scheme_select && last_grant[k])) begin
                winner  = 2'(k);
                any_win = 1'b1;
            end
        end
        if (!any_win) begin
            for (int k = NUM_CH - 1; k >= 0; k--) begin
                if (pending[k] && live[k]) begin
                    idx     = 2'(k);
                    any_win = 1'b1;
                end
            end
            winner = idx;
        end
    end

    wire dma_pkg::channel_control_s cc = ctl[cur];
    wire [15:0] src_addr = (cc.source_addressing_field == dma_pkg::ADDR_INDIRECT && indirect_offset_valid[cur])
                           ? source_pointer[cur] + indirect_offset : source_pointer[cur];
    wire [15:0] dst_addr = (cc.destination_addressing_field == dma_pkg::ADDR_INDIRECT && indirect_offset_valid[cur])
                           ? destination_pointer[cur] + indirect_offset : destination_pointer[cur];
    wire [15:0] cur_addr = (state == S_WRITE) ? dst_addr : src_addr;
    wire        violation = (state != S_IDLE) && !in_limits(cur_addr);
    wire        cur_cont = cc.transfer_mode_field[1];
    wire        cur_rep  = (cc.transfer_mode_field == dma_pkg::MODE_REP_ONE_SHOT) ||
                           (cc.transfer_mode_field == dma_pkg::MODE_REP_CONTINUOUS);
    wire [15:0] next_count = transaction_counter[cur] - 16'h0001;
    wire        write_done = mem_ready && ((state == S_DUMMY) || (state == S_WRITE && !cc.dummy_write_enable));
    wire        finished   = write_done && (next_count == 16'h0000);

    // Byte lane from address LSB
    wire [15:0] lane_data = cc.byte_size ? (cur_addr[0] ? {8'h00, mem_rdata[15:8]} : {8'h00, mem_rdata[7:0]})
                                         : mem_rdata;

    always_comb begin
        mem_req.valid     = (state != S_IDLE) && !violation;
        mem_req.write     = (state == S_WRITE) || (state == S_DUMMY);
        mem_req.byte_size = cc.byte_size;
        mem_req.addr      = (state == S_DUMMY) ? src_addr : cur_addr;
        mem_req.wdata     = cc.byte_size ? {transfer_data_buffer[7:0], transfer_data_buffer[7:0]}
                                         : transfer_data_buffer;
    end

    // Engine sequencer
    always_ff @(posedge clk) begin
        if (rst || !engine_enable || (state != S_IDLE && !live[cur])) begin
            state <= S_IDLE;
            cur   <= 2'd0;
        end else begin
            case (state)
                S_IDLE: if (any_win) begin
                    state <= S_READ;
                    cur   <= winner;
                end
                S_READ:  if (violation) state <= S_IDLE;
                         else if (mem_ready) state <= S_WRITE;
                S_WRITE: if (violation) state <= S_IDLE;
                         else if (mem_ready) state <= cc.dummy_write_enable ? S_DUMMY :
                                              ((cur_cont && !finished) ? S_READ : S_IDLE);
                S_DUMMY: if (violation) state <= S_IDLE;
                         else if (mem_ready) state <= (cur_cont && !finished) ? S_READ : S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            transfer_data_buffer <= dma_pkg::RESET_VALUE;
            last_grant           <= '0;
        end else begin
            if (state == S_READ && mem_ready && !violation) transfer_data_buffer <= lane_data;
            if (state == S_IDLE && any_win) last_grant <= NUM_CH'(1) << winner;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            engine_enable          <= 1'b0;
            priority_scheme_select <= 1'b0;
            upper_address_limit    <= dma_pkg::RESET_VALUE;
            lower_address_limit    <= dma_pkg::RESET_VALUE;
            module_power_down      <= '0;
        end else if (reg_write && !is_ch) begin
            case (reg_addr)
                dma_pkg::OFF_ENGINE_CONTROL: begin
                    engine_enable          <= reg_wdata[dma_pkg::BIT_ENGINE_ENABLE];
                    priority_scheme_select <= reg_wdata[dma_pkg::BIT_PRIORITY_SEL];
                end
                dma_pkg::OFF_UPPER_LIMIT: upper_address_limit <= reg_wdata;
                dma_pkg::OFF_LOWER_LIMIT: lower_address_limit <= reg_wdata;
                dma_pkg::OFF_POWER_DOWN:  module_power_down   <= reg_wdata[NUM_CH-1:0];
                default: ;
            endcase
        end
    end

    // Per-channel state
    for (g = 0; g < NUM_CH; g++) begin : g_ch
        wire wr      = reg_write && ch_hit && (32'(sel_ch) == g);
        wire active  = (state != S_IDLE) && (32'(cur) == g);
        wire granted = (state == S_IDLE) && any_win && (32'(winner) == g);
        wire rep     = (ctl[g].transfer_mode_field == dma_pkg::MODE_REP_ONE_SHOT) ||
                       (ctl[g].transfer_mode_field == dma_pkg::MODE_REP_CONTINUOUS);
        wire fin     = active && finished;
        wire viol    = active && violation;
        wire trig    = trigger[g] && live[g];
        // End of the work one trigger asks for: one transaction, or the whole run when continuous
        wire op_end  = active && write_done && !violation && (!cur_cont || finished);
        wire [3:0] flag_clear = {reg_wdata[dma_pkg::BIT_HIGH_IF], reg_wdata[dma_pkg::BIT_LOW_IF],
                                 reg_wdata[dma_pkg::BIT_DONE_IF], reg_wdata[dma_pkg::BIT_OVRUN_IF]};
        always_ff @(posedge clk) begin
            if (rst) begin
                ctl[g]                 <= dma_pkg::channel_control_s'(dma_pkg::RESET_VALUE);
                source_pointer[g]      <= dma_pkg::RESET_VALUE;
                destination_pointer[g] <= dma_pkg::RESET_VALUE;
                transaction_counter[g] <= dma_pkg::RESET_VALUE;
                original_count[g]      <= dma_pkg::RESET_VALUE;
                src_start[g]           <= dma_pkg::RESET_VALUE;
                dst_start[g]           <= dma_pkg::RESET_VALUE;
                flags[g]               <= 4'h0;
                pending[g]             <= 1'b0;
                restart[g]             <= 1'b0;
            end else begin
                if (wr && sel_sub == dma_pkg::SUB_CONTROL) ctl[g] <= reg_wdata & dma_pkg::CH_CONTROL_MASK;
                if (wr && sel_sub == dma_pkg::SUB_SOURCE) begin
                    source_pointer[g] <= reg_wdata;
                    src_start[g]      <= reg_wdata;
                end
                if (wr && sel_sub == dma_pkg::SUB_DEST) begin
                    destination_pointer[g] <= reg_wdata;
                    dst_start[g]           <= reg_wdata;
                end
                if (wr && sel_sub == dma_pkg::SUB_COUNT) begin
                    transaction_counter[g] <= reg_wdata;
                    original_count[g]      <= reg_wdata;
                end
                if (wr && sel_sub == dma_pkg::SUB_INTERRUPT) flags[g] <= flags[g] & ~flag_clear;
                // Hardware sets win over software clears
                if (trig && active) flags[g][0] <= 1'b1;
                if (viol) flags[g][(cur_addr > upper_address_limit) ? 3 : 2] <= 1'b1;
                if (fin) flags[g][1] <= 1'b1;
                if (granted && restart[g]) begin
                    if (ctl[g].reload) begin
                        source_pointer[g]      <= src_start[g];
                        destination_pointer[g] <= dst_start[g];
                    end
                    if (ctl[g].reload || rep) transaction_counter[g] <= original_count[g];
                    restart[g] <= 1'b0;
                end
                if (active && write_done && !violation) begin
                    source_pointer[g]      <= step(source_pointer[g], ctl[g].source_addressing_field,
                                                   ctl[g].byte_size);
                    destination_pointer[g] <= step(destination_pointer[g], ctl[g].destination_addressing_field,
                                                   ctl[g].byte_size);
                    transaction_counter[g] <= next_count;
                end
                if (trig || (live[g] && ctl[g].software_request && !active)) pending[g] <= 1'b1;
                if (granted || !live[g]) pending[g] <= 1'b0;
                if (fin || viol) begin
                    restart[g] <= 1'b1;
                    if (!rep && fin) ctl[g].channel_enable <= 1'b0;
                end
                // A software request counts as one trigger, so it must not retrigger itself
                if (op_end || viol) ctl[g].software_request <= 1'b0;
            end
        end
        assign channel_event[g] = fin || viol;
    end

    // Read mux; unused bits read zero
    always_comb begin
        read_data = 16'h0000;
        if (ch_hit) begin
            case (sel_sub)
                dma_pkg::SUB_CONTROL:   read_data = ctl[sel_ch];
                dma_pkg::SUB_INTERRUPT: read_data = {8'h00, flags[sel_ch][3], flags[sel_ch][2], flags[sel_ch][1],
                                                     1'b0, flags[sel_ch][0], 3'h0};
                dma_pkg::SUB_SOURCE:    read_data = source_pointer[sel_ch];
                dma_pkg::SUB_DEST:      read_data = destination_pointer[sel_ch];
                dma_pkg::SUB_COUNT:     read_data = transaction_counter[sel_ch];
                default:                read_data = 16'h0000;
            endcase
        end else begin
            case (reg_addr)
                dma_pkg::OFF_ENGINE_CONTROL: read_data = {engine_enable, 14'h0000, priority_scheme_select};
                dma_pkg::OFF_UPPER_LIMIT:    read_data = upper_address_limit;
                dma_pkg::OFF_LOWER_LIMIT:    read_data = lower_address_limit;
                dma_pkg::OFF_DATA_BUFFER:    read_data = transfer_data_buffer;
                dma_pkg::OFF_POWER_DOWN:     read_data = 16'(module_power_down);
                default:                     read_data = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) reg_rdata <= 16'h0000;
        else     reg_rdata <= reg_read ? read_data : 16'h0000;
    end

    property p_disable_aborts;
        @(posedge clk) disable iff (rst) !engine_enable |=> state == S_IDLE && !mem_req.valid;
    endproperty
    a_disable_aborts: assert property (p_disable_aborts) else $error("engine off but busy");

    property p_dummy_follows;
        @(posedge clk) disable iff (rst)
            (state == S_WRITE && mem_ready && cc.dummy_write_enable && !violation && live[cur] && engine_enable)
            |=> state == S_DUMMY;
    endproperty
    a_dummy_follows: assert property (p_dummy_follows) else $error("dummy write missing");

    property p_no_dummy;
        @(posedge clk) disable iff (rst) (state == S_WRITE && !cc.dummy_write_enable) |=> state != S_DUMMY;
    endproperty
    a_no_dummy: assert property (p_no_dummy) else $error("unexpected dummy write");

    property p_reg_ctl;
        @(posedge clk) disable iff (rst)
            reg_read && reg_addr == dma_pkg::OFF_ENGINE_CONTROL |=> reg_rdata[14:1] == 14'h0000;
    endproperty
    a_reg_ctl: assert property (p_reg_ctl) else $error("reserved bits nonzero");

    property p_disabled_idle;
        @(posedge clk) disable iff (rst) (state == S_IDLE && (pending & live) == '0) |=> state == S_IDLE;
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) else $error("disabled channel started");

    property p_count_dec;
        @(posedge clk) disable iff (rst)
            (write_done && !violation && live[cur] && engine_enable) |=> transaction_counter[$past(cur)] ==
            $past(transaction_counter[cur]) - 16'h0001;
    endproperty
    a_count_dec: assert property (p_count_dec) else $error("count did not step");

    property p_limit_blocks;
        @(posedge clk) disable iff (rst) violation |-> !mem_req.valid ##1 state == S_IDLE;
    endproperty
    a_limit_blocks: assert property (p_limit_blocks) else $error("limit violation accessed");

    property p_oneshot_stops;
        @(posedge clk) disable iff (rst) (write_done && !cur_cont && !violation) |=> state == S_IDLE;
    endproperty
    a_oneshot_stops: assert property (p_oneshot_stops) else $error("one-shot continued");
endmodule // multichannel_dma_control

/* shared/dma_pkg.sv */
// Register map, field layout and types of the four-channel DMA controller
package dma_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam int NUM_CH = 4;
    // Module-level registers
    localparam logic [5:0] OFF_ENGINE_CONTROL = 6'h00;
    localparam logic [5:0] OFF_UPPER_LIMIT    = 6'h01;
    localparam logic [5:0] OFF_LOWER_LIMIT    = 6'h02;
    localparam logic [5:0] OFF_DATA_BUFFER    = 6'h03;
    localparam logic [5:0] OFF_POWER_DOWN     = 6'h04;
    // Per channel: base 08h, stride 8
    localparam logic [5:0] OFF_CH_BASE        = 6'h08;
    localparam int         CH_STRIDE_LOG2     = 3;
    localparam logic [2:0] SUB_CONTROL        = 3'h0;
    localparam logic [2:0] SUB_INTERRUPT      = 3'h1;
    localparam logic [2:0] SUB_SOURCE         = 3'h2;
    localparam logic [2:0] SUB_DEST           = 3'h3;
    localparam logic [2:0] SUB_COUNT          = 3'h4;
    // Engine control fields
    localparam int BIT_ENGINE_ENABLE = 15;
    localparam int BIT_PRIORITY_SEL  = 0;
    // Channel control fields
    localparam int BIT_DUMMY_WRITE   = 10;
    localparam int BIT_RELOAD        = 9;
    localparam int BIT_SW_REQUEST    = 8;
    localparam int BIT_SIZE          = 1;
    localparam int BIT_CH_ENABLE     = 0;
    localparam logic [15:0] CH_CONTROL_MASK = 16'h07FF;
    // Interrupt register flag positions
    localparam int BIT_HIGH_IF  = 7;
    localparam int BIT_LOW_IF   = 6;
    localparam int BIT_DONE_IF  = 5;
    localparam int BIT_OVRUN_IF = 3;
    localparam logic [15:0] RESET_VALUE = 16'h0000;

    typedef enum logic [1:0] {
        ADDR_HOLD = 2'b00, ADDR_INC = 2'b01, ADDR_DEC = 2'b10, ADDR_INDIRECT = 2'b11
    } addr_mode_e;
    typedef enum logic [1:0] {
        MODE_ONE_SHOT = 2'b00, MODE_REP_ONE_SHOT = 2'b01, MODE_CONTINUOUS = 2'b10, MODE_REP_CONTINUOUS = 2'b11
    } transfer_mode_e;

    typedef struct packed {
        logic [4:0]     unused_hi;
        logic           dummy_write_enable;
        logic           reload;
        logic           software_request;
        addr_mode_e     source_addressing_field;
        addr_mode_e     destination_addressing_field;
        transfer_mode_e transfer_mode_field;
        logic           byte_size;
        logic           channel_enable;
    } channel_control_s;

    // Memory-side request issued by the engine
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        byte_size;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mem_req_s;
endpackage

/* tb/dma_memory_model.sv */
// Memory partner answering engine requests after a programmable stall
`timescale 1ns/1ps
module dma_memory_model (
    input  wire logic         clk,
    input  wire logic         rst,
    input  dma_pkg::mem_req_s req,
    input  wire logic [3:0]   stall,
    output logic              ready,
    output logic [15:0]       rdata,
    output int                reads,
    output int                writes
);
    logic [3:0]  wait_cnt;
    logic [15:0] last;
    assign ready = req.valid && (wait_cnt == stall);
    // Idle bus shows the inverse of its previous value, so it returns to the last answer every other cycle
    assign rdata = (ready && !req.write) ? (req.addr ^ 16'h5A5A) : ~last;
    always_ff @(posedge clk) begin
        if (rst) begin
            wait_cnt <= 4'h0;
            last     <= 16'h0000;
            reads    <= 0;
            writes   <= 0;
        end else begin
            wait_cnt <= (ready || !req.valid) ? 4'h0 : wait_cnt + 4'h1;
            last     <= rdata;
            if (ready && req.write) writes <= writes + 1;
            if (ready && !req.write) reads <= reads + 1;
        end
    end
endmodule // dma_memory_model

/* tb/test_multichannel_dma_control.sv */
// Self-checking bench for the four-channel DMA controller
`timescale 1ns/1ps
module test_multichannel_dma_control;
    logic clk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, mem_ready;
    logic [5:0]  reg_addr = 6'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, mem_rdata, got, indirect_offset = 16'h0000;
    logic [3:0]  trigger = 4'h0, channel_event, stall = 4'h0, seen = 4'h0, indirect_valid = 4'h0;
    int fails = 0, cmp_count = 0, reads, writes, r0, w0;
    dma_pkg::mem_req_s mem_req;
    multichannel_dma_control i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .trigger(trigger),
        .indirect_offset_valid(indirect_valid), .indirect_offset(indirect_offset), .mem_req(mem_req),
        .mem_ready(mem_ready), .mem_rdata(mem_rdata), .channel_event(channel_event));
    dma_memory_model i_mem (.clk(clk), .rst(rst), .req(mem_req), .stall(stall), .ready(mem_ready),
        .rdata(mem_rdata), .reads(reads), .writes(writes));
    initial forever #5 clk = ~clk;
    always @(posedge clk) seen <= seen | channel_event;
    function automatic logic [5:0] ch(int n, logic [2:0] sub);
        return dma_pkg::OFF_CH_BASE + 6'(n << dma_pkg::CH_STRIDE_LOG2) + 6'(sub);
    endfunction
    task automatic chk(string name, logic [15:0] exp, logic [15:0] val);
        cmp_count++;
        if (val !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, val);
        end
    endtask
    task automatic wr(logic [5:0] a, logic [15:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(logic [5:0] a);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 got = reg_rdata;
    endtask
    task automatic rc(string name, logic [5:0] a, logic [15:0] exp);
        rd(a);
        chk(name, exp, got);
    endtask
    task automatic setup(int n, logic [15:0] s, logic [15:0] d, logic [15:0] c, logic [15:0] ctl);
        r0 = reads;
        w0 = writes;
        wr(ch(n, dma_pkg::SUB_CONTROL), 16'h0000);
        wr(ch(n, dma_pkg::SUB_SOURCE), s);
        wr(ch(n, dma_pkg::SUB_DEST), d);
        wr(ch(n, dma_pkg::SUB_COUNT), c);
        wr(ch(n, dma_pkg::SUB_CONTROL), ctl);
    endtask
    task automatic first_event(string name, logic [3:0] fire, logic [3:0] exp);
        trigger <= fire;
        @(posedge clk);
        trigger <= 4'h0;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            #1;
            if (channel_event != 4'h0) break;
        end
        chk(name, 16'(exp), 16'(channel_event));
        repeat (20) @(posedge clk);
    endtask
    task automatic wait_req_clear(int n);
        for (int i = 0; i < 100; i++) begin
            rd(ch(n, dma_pkg::SUB_CONTROL));
            if (got[dma_pkg::BIT_SW_REQUEST] === 1'b0) break;
        end
    endtask
    task automatic t_registers;
        wr(dma_pkg::OFF_ENGINE_CONTROL, 16'hFFFF);
        rc("engine_control", dma_pkg::OFF_ENGINE_CONTROL, 16'h8001);
        rc("unmapped", 6'h3F, 16'h0000);
        wr(ch(2, dma_pkg::SUB_CONTROL), 16'hE6FE);
        rc("channel_control", ch(2, dma_pkg::SUB_CONTROL), 16'h06FE);
        wr(dma_pkg::OFF_ENGINE_CONTROL, 16'h8000);
        wr(dma_pkg::OFF_UPPER_LIMIT, 16'h4FFF);
        wr(dma_pkg::OFF_LOWER_LIMIT, 16'h1000);
    endtask
    // Software request, one-shot word copy: one transaction only
    task automatic t_one_shot_word;
        setup(0, 16'h1000, 16'h1100, 16'h0002, 16'h0151);
        wait_req_clear(0);
        chk("control0", 16'h0051, got);
        rc("count0", ch(0, dma_pkg::SUB_COUNT), 16'h0001);
        rc("source0", ch(0, dma_pkg::SUB_SOURCE), 16'h1002);
        rc("dest0", ch(0, dma_pkg::SUB_DEST), 16'h1102);
        chk("reads0", 16'h0001, 16'(reads - r0));
        chk("writes0", 16'h0001, 16'(writes - w0));
    endtask
    // Continuous byte copy with null write against a stalling memory
    task automatic t_continuous_null;
        stall <= 4'h2;
        setup(1, 16'h1010, 16'h1200, 16'h0002, 16'h058B);
        wait_req_clear(1);
        chk("control1", 16'h048A, got);
        rc("count1", ch(1, dma_pkg::SUB_COUNT), 16'h0000);
        rc("source1", ch(1, dma_pkg::SUB_SOURCE), 16'h100E);
        rc("dest1", ch(1, dma_pkg::SUB_DEST), 16'h1200);
        rc("buffer1", dma_pkg::OFF_DATA_BUFFER, 16'h004A);
        chk("reads1", 16'h0002, 16'(reads - r0));
        chk("writes1", 16'h0004, 16'(writes - w0));
        chk("event1", 16'h0001, 16'(seen[1]));
    endtask
    task automatic t_disabled;
        setup(2, 16'h1000, 16'h1300, 16'h0001, 16'h0050);
        trigger <= 4'h4;
        repeat (20) @(posedge clk);
        trigger <= 4'h0;
        rc("count2", ch(2, dma_pkg::SUB_COUNT), 16'h0001);
        chk("traffic2", 16'h0000, 16'(reads - r0 + writes - w0));
    endtask
    // Peripheral offset added to the base; the pointer itself is held
    task automatic t_indirect;
        indirect_valid  <= 4'h4;
        indirect_offset <= 16'h0020;
        setup(2, 16'h1000, 16'h1300, 16'h0001, 16'h01C1);
        wait_req_clear(2);
        indirect_valid <= 4'h0;
        chk("control2", 16'h00C0, got);
        rc("buffer2", dma_pkg::OFF_DATA_BUFFER, 16'h4A7A);
        rc("source2", ch(2, dma_pkg::SUB_SOURCE), 16'h1000);
    endtask
    // Destination above the upper limit: no write, high flag, cleared by writing one
    task automatic t_limit;
        setup(0, 16'h1000, 16'h5000, 16'h0001, 16'h0101);
        wait_req_clear(0);
        chk("writes_limit", 16'h0000, 16'(writes - w0));
        rc("count_limit", ch(0, dma_pkg::SUB_COUNT), 16'h0001);
        rc("flags_limit", ch(0, dma_pkg::SUB_INTERRUPT), 16'h0080);
        wr(ch(0, dma_pkg::SUB_INTERRUPT), 16'h0080);
        rc("flags_cleared", ch(0, dma_pkg::SUB_INTERRUPT), 16'h0000);
    endtask
    // Colliding repeated one-shot channels: fixed picks the lowest, round robin skips the last grant
    task automatic t_arbitration;
        wr(dma_pkg::OFF_ENGINE_CONTROL, 16'h8000);
        setup(0, 16'h1000, 16'h1100, 16'h0001, 16'h0005);
        setup(1, 16'h1000, 16'h1200, 16'h0001, 16'h0005);
        first_event("fixed_first", 4'h3, 4'h1);
        wr(dma_pkg::OFF_ENGINE_CONTROL, 16'h8001);
        first_event("single_grant", 4'h1, 4'h1);
        first_event("round_robin", 4'h3, 4'h2);
    endtask
    task automatic t_abort;
        stall <= 4'hF;
        setup(3, 16'h1000, 16'h1400, 16'h0004, 16'h0159);
        for (int i = 0; i < 20 && mem_req.valid !== 1'b1; i++) @(posedge clk);
        wr(dma_pkg::OFF_ENGINE_CONTROL, 16'h0000);
        repeat (2) @(posedge clk);
        #1 chk("abort_valid", 16'h0000, 16'(mem_req.valid));
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rc("reset_engine", dma_pkg::OFF_ENGINE_CONTROL, 16'h0000);
        t_registers();
        t_one_shot_word();
        t_continuous_null();
        t_disabled();
        t_indirect();
        t_limit();
        t_arbitration();
        t_abort();
        give_verdict();
    end
endmodule // test_multichannel_dma_control
